/* rtl/rrf_pkg.sv */
package rrf_pkg;

   // Management message type values for the two request forms.
   localparam logic [7:0] RRF_TYPE_SINGLE = 8'h06;
   localparam logic [7:0] RRF_TYPE_MULTI = 8'h2c;

   // Top-level tuple type codes; the framer recognises the first three.
   localparam logic [7:0] RRF_TLV_VENDOR_ID = 8'h08;
   localparam logic [7:0] RRF_TLV_MODEM_CAP = 8'h05;
   localparam logic [7:0] RRF_TLV_RX_PROFILE = 8'h31;
   localparam logic [7:0] RRF_TLV_MODEM_IP = 8'h0c;
   localparam logic [7:0] RRF_TLV_VEND_CAP = 8'h2b;

   // Inclusion groups for configuration-file tuples.
   typedef enum logic [1:0] {
      RRF_GRP_NONE,
      RRF_GRP_LEGACY_MIC,
      RRF_GRP_EXT_BITMAP,
      RRF_GRP_UNPROTECTED
   } rrf_group_t;

   // Largest management payload of one fragment, in bytes.
   localparam logic [15:0] RRF_MAX_PAYLOAD = 16'd1500;
   // Header bytes of each fragment: type, identifier (2), count, sequence.
   localparam logic [15:0] RRF_HDR_BYTES = 16'd5;
   // Fragment storage in bytes; the framer holds the whole message.
   localparam int RRF_STORE_BYTES = 16384;
   localparam int RRF_ADDR_W = 14;
   localparam int RRF_FIFO_DEPTH = 4;
   localparam logic [7:0] RRF_FIRST_SEQ = 8'h01;

   // Byte on the link between modem framer and headend receiver.
   typedef struct packed {
      logic [7:0] data;
      logic sof;
      logic eof;
   } rrf_beat_t;

   localparam int RRF_BEAT_W = $bits(rrf_beat_t);

   // Running CRC-32 over one byte, reflected form.
   function automatic logic [31:0] rrf_crc_byte(input logic [31:0] crc, input logic [7:0] b);
      logic [31:0] c;
      c = crc ^ {24'h000000, b};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
      return c;
   endfunction

endpackage

/* rtl/rrf_link_if.sv */
`timescale 1ns/1ps
interface rrf_link_if;
   logic valid;
   logic ready;
   logic [7:0] data;
   logic sof;
   logic eof;

   modport modem (output valid, output data, output sof, output eof, input ready);
   modport headend (input valid, input data, input sof, input eof, output ready);
endinterface

/* rtl/rrf_fifo.sv */
`timescale 1ns/1ps
module rrf_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } rrf_fifo_st_t;

   rrf_fifo_st_t s_q;
   rrf_fifo_st_t s_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic push;
   logic pop;

   assign in_ready_o = (s_q.cnt != DEPTH[AW:0]);
   assign out_valid_o = (s_q.cnt != '0);
   assign out_data_o = mem_q[s_q.rp];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.wp = s_q.wp + 1'b1;
      end
      if (pop)
      begin
         s_d.rp = s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
      if (push)
      begin
         mem_q[s_q.wp] <= in_data_i;
      end
   end
endmodule

/* rtl/rrf_modem_framer.sv */
`timescale 1ns/1ps
module rrf_modem_framer
   import rrf_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic [15:0] SERVICE_ID_I,
   input wire logic CFG_DONE_I,
   input wire logic TLV_VALID_I,
   output logic TLV_READY_O,
   input wire logic [7:0] TLV_DATA_I,
   input wire logic TLV_FIRST_I,
   input wire logic TLV_LAST_I,
   input wire rrf_pkg::rrf_group_t TLV_GROUP_I,
   input wire logic TLV_SELF_I,
   input wire logic [15:0] TLV_LEN_I,
   input wire logic GEN_DONE_I,
   output logic BUSY_O,
   output logic DONE_O,
   output logic ERROR_O,
   output logic [7:0] FRAG_COUNT_O,
   rrf_link_if.modem link
);
   import rrf_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_COLLECT,
      ST_CHECK,
      ST_SEND,
      ST_CRC,
      ST_DONE
   } rrf_state_t;

   typedef struct packed {
      rrf_state_t st;
      logic cfg_seen;
      logic keep;
      logic [RRF_ADDR_W-1:0] wr_ptr;
      logic [15:0] frag_fill;
      logic [7:0] frag_cnt;
      logic [RRF_ADDR_W-1:0] rd_ptr;
      logic [7:0] seq;
      logic [15:0] rd_left;
      logic [2:0] hdr_idx;
      logic [1:0] crc_idx;
      logic [31:0] crc;
      logic seen_cap;
      logic seen_vid;
      logic seen_rcp;
      logic busy;
      logic done;
      logic error;
      logic tready;
   } rrf_mstate_t;

   rrf_mstate_t s_q;
   rrf_mstate_t s_d;

   // Tuple bytes in file order, plus the byte length of each fragment body.
   logic [7:0] store_q [RRF_STORE_BYTES];
   logic [15:0] flen_q [256];
   logic store_we;
   logic flen_we;
   logic [7:0] flen_idx;
   logic [15:0] flen_val;

   logic f_valid;
   logic f_ready;
   rrf_beat_t f_beat;
   rrf_beat_t out_beat;
   logic [7:0] hdr_byte;
   logic [15:0] need;

   always_comb
   begin
      unique case (s_q.hdr_idx)
         3'd0: hdr_byte = RRF_TYPE_MULTI;
         3'd1: hdr_byte = SERVICE_ID_I[15:8];
         3'd2: hdr_byte = SERVICE_ID_I[7:0];
         3'd3: hdr_byte = s_q.frag_cnt;
         default: hdr_byte = s_q.seq;
      endcase
   end

   assign need = s_q.frag_fill + TLV_LEN_I;
   assign TLV_READY_O = s_q.tready;

   always_comb
   begin
      s_d = s_q;
      store_we = 1'b0;
      flen_we = 1'b0;
      flen_idx = 8'h00;
      flen_val = 16'h0000;
      f_valid = 1'b0;
      f_beat = '0;
      if (CFG_DONE_I)
      begin
         s_d.cfg_seen = 1'b1;
      end
      unique case (s_q.st)
         ST_IDLE:
         begin
            // Nothing is built until the configuration file is in.
            if (s_q.cfg_seen)
            begin
               s_d.st = ST_COLLECT;
               s_d.busy = 1'b1;
               s_d.done = 1'b0;
               s_d.error = 1'b0;
               s_d.wr_ptr = '0;
               s_d.frag_fill = RRF_HDR_BYTES;
               s_d.frag_cnt = RRF_FIRST_SEQ;
               s_d.seen_cap = 1'b0;
               s_d.seen_vid = 1'b0;
               s_d.seen_rcp = 1'b0;
            end
         end
         ST_COLLECT:
         begin
            if (TLV_VALID_I)
            begin
               if (TLV_FIRST_I)
               begin
                  // Self-made tuples always pass; file tuples only by group.
                  s_d.keep = TLV_SELF_I || (TLV_GROUP_I != RRF_GRP_NONE);
                  if (TLV_SELF_I && TLV_DATA_I == RRF_TLV_MODEM_CAP)
                  begin
                     s_d.seen_cap = 1'b1;
                  end
                  if (TLV_SELF_I && TLV_DATA_I == RRF_TLV_VENDOR_ID)
                  begin
                     s_d.seen_vid = 1'b1;
                  end
                  if (TLV_SELF_I && TLV_DATA_I == RRF_TLV_RX_PROFILE)
                  begin
                     s_d.seen_rcp = 1'b1;
                  end
                  if ((TLV_SELF_I || TLV_GROUP_I != RRF_GRP_NONE) && need > RRF_MAX_PAYLOAD)
                  begin
                     // Close this fragment so the tuple stays whole.
                     flen_we = 1'b1;
                     flen_idx = s_q.frag_cnt;
                     flen_val = s_q.frag_fill - RRF_HDR_BYTES;
                     s_d.frag_cnt = s_q.frag_cnt + 8'h01;
                     s_d.frag_fill = RRF_HDR_BYTES + 16'd1;
                  end
                  else if (TLV_SELF_I || TLV_GROUP_I != RRF_GRP_NONE)
                  begin
                     s_d.frag_fill = s_q.frag_fill + 16'd1;
                  end
                  store_we = TLV_SELF_I || (TLV_GROUP_I != RRF_GRP_NONE);
               end
               else if (s_q.keep)
               begin
                  // Bytes are stored strictly in arrival order.
                  store_we = 1'b1;
                  s_d.frag_fill = s_q.frag_fill + 16'd1;
               end
               if (store_we)
               begin
                  s_d.wr_ptr = s_q.wr_ptr + 1'b1;
               end
            end
            else if (GEN_DONE_I)
            begin
               flen_we = 1'b1;
               flen_idx = s_q.frag_cnt;
               flen_val = s_q.frag_fill - RRF_HDR_BYTES;
               s_d.st = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            // Mandatory tuples missing means no request goes out.
            s_d.rd_ptr = '0;
            s_d.seq = RRF_FIRST_SEQ;
            s_d.hdr_idx = 3'd0;
            s_d.crc = 32'hffffffff;
            if (s_q.seen_cap && s_q.seen_vid && s_q.seen_rcp)
            begin
               s_d.st = ST_SEND;
               s_d.rd_left = flen_q[RRF_FIRST_SEQ];
            end
            else
            begin
               s_d.st = ST_DONE;
               s_d.error = 1'b1;
            end
         end
         ST_SEND:
         begin
            f_valid = 1'b1;
            f_beat.sof = (s_q.hdr_idx == 3'd0);
            if (s_q.hdr_idx < 3'd5)
            begin
               // Header: multipart type, identifier, final count, sequence.
               f_beat.data = hdr_byte;
            end
            else
            begin
               f_beat.data = store_q[s_q.rd_ptr];
            end
            if (f_ready)
            begin
               s_d.crc = rrf_crc_byte(s_q.crc, f_beat.data);
               if (s_q.hdr_idx < 3'd5)
               begin
                  s_d.hdr_idx = s_q.hdr_idx + 3'd1;
               end
               else
               begin
                  s_d.rd_ptr = s_q.rd_ptr + 1'b1;
                  s_d.rd_left = s_q.rd_left - 16'd1;
               end
               if ((s_q.hdr_idx == 3'd4 && s_q.rd_left == 16'd0) ||
                   (s_q.hdr_idx == 3'd5 && s_q.rd_left == 16'd1))
               begin
                  s_d.st = ST_CRC;
                  s_d.crc_idx = 2'd0;
               end
            end
         end
         ST_CRC:
         begin
            // Each fragment ends with its own CRC, so it stands alone.
            f_valid = 1'b1;
            f_beat.data = ~s_q.crc[8*s_q.crc_idx +: 8];
            f_beat.eof = (s_q.crc_idx == 2'd3);
            if (f_ready)
            begin
               s_d.crc_idx = s_q.crc_idx + 2'd1;
               if (s_q.crc_idx == 2'd3)
               begin
                  s_d.crc = 32'hffffffff;
                  s_d.hdr_idx = 3'd0;
                  if (s_q.seq == s_q.frag_cnt)
                  begin
                     s_d.st = ST_DONE;
                  end
                  else
                  begin
                     s_d.st = ST_SEND;
                     s_d.seq = s_q.seq + 8'h01;
                     s_d.rd_left = flen_q[s_q.seq + 8'h01];
                  end
               end
            end
         end
         ST_DONE:
         begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.cfg_seen = CFG_DONE_I;
            s_d.st = ST_IDLE;
         end
      endcase
      s_d.tready = (s_d.st == ST_COLLECT);
   end

   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         s_q <= '{st: ST_IDLE, crc: 32'hffffffff, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
      if (store_we)
      begin
         store_q[s_q.wr_ptr] <= TLV_DATA_I;
      end
      if (flen_we)
      begin
         flen_q[flen_idx] <= flen_val;
      end
   end

   rrf_fifo #(.WIDTH(RRF_BEAT_W), .DEPTH(RRF_FIFO_DEPTH)) u_fifo (
      .clk_i(MCLK_I),
      .rst_i(RST_I),
      .in_valid_i(f_valid),
      .in_ready_o(f_ready),
      .in_data_i(f_beat),
      .out_valid_o(link.valid),
      .out_ready_i(link.ready),
      .out_data_o(out_beat)
   );

   assign link.data = out_beat.data;
   assign link.sof = out_beat.sof;
   assign link.eof = out_beat.eof;
   assign BUSY_O = s_q.busy;
   assign DONE_O = s_q.done;
   assign ERROR_O = s_q.error;
   assign FRAG_COUNT_O = s_q.frag_cnt;
endmodule

/* rtl/rrf_headend_rx.sv */
`timescale 1ns/1ps
module rrf_headend_rx
   import rrf_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic STALL_I,
   output logic FRAG_OK_O,
   output logic FRAG_BAD_O,
   output logic [7:0] SEQ_O,
   output logic [7:0] COUNT_O,
   output logic [15:0] SERVICE_ID_O,
   output logic MSG_DONE_O,
   output logic [15:0] TOTAL_BYTES_O,
   rrf_link_if.headend link
);
   import rrf_pkg::*;

   typedef struct packed {
      logic [2:0] hidx;
      logic [31:0] crc;
      logic [7:0] exp_seq;
      logic [15:0] total;
      logic [15:0] service_identifier;
      logic [7:0] cnt;
      logic [7:0] seq;
      logic ok;
      logic bad;
      logic done;
      logic ready;
   } rrf_hstate_t;

   rrf_hstate_t s_q;
   rrf_hstate_t s_d;
   logic [31:0] crc_n;

   assign link.ready = s_q.ready;

   always_comb
   begin
      s_d = s_q;
      s_d.ok = 1'b0;
      s_d.bad = 1'b0;
      s_d.done = 1'b0;
      s_d.ready = ~STALL_I;
      crc_n = rrf_crc_byte(link.sof ? 32'hffffffff : s_q.crc, link.data);
      if (link.valid && s_q.ready)
      begin
         // Each fragment is parsed on its own, no reassembly buffer.
         s_d.crc = crc_n;
         s_d.hidx = (s_q.hidx < 3'd5 && !link.sof) ? s_q.hidx + 3'd1 : s_q.hidx;
         if (link.sof)
         begin
            s_d.hidx = 3'd1;
         end
         unique case (s_q.hidx)
            3'd1: s_d.service_identifier[15:8] = link.data;
            3'd2: s_d.service_identifier[7:0] = link.data;
            3'd3: s_d.cnt = link.data;
            3'd4: s_d.seq = link.data;
            default: ;
         endcase
         if (!link.sof && s_q.hidx == 3'd5)
         begin
            s_d.total = s_q.total + 16'd1;
         end
         if (link.eof)
         begin
            s_d.hidx = 3'd0;
            // Residue check of the appended CRC.
            if (crc_n == 32'hdebb20e3 && s_q.seq == s_q.exp_seq)
            begin
               s_d.ok = 1'b1;
               s_d.exp_seq = s_q.exp_seq + 8'h01;
               if (s_q.seq == s_q.cnt)
               begin
                  s_d.done = 1'b1;
                  s_d.exp_seq = RRF_FIRST_SEQ;
               end
            end
            else
            begin
               s_d.bad = 1'b1;
               s_d.exp_seq = RRF_FIRST_SEQ;
            end
            // Three CRC bytes were counted as body; the last one was not.
            s_d.total = s_q.total - 16'd3;
         end
         if (link.sof && s_q.exp_seq == RRF_FIRST_SEQ)
         begin
            s_d.total = 16'h0000;
         end
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         s_q <= '{exp_seq: 8'h01, crc: 32'hffffffff, default: '0};
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign FRAG_OK_O = s_q.ok;
   assign FRAG_BAD_O = s_q.bad;
   assign SEQ_O = s_q.seq;
   assign COUNT_O = s_q.cnt;
   assign SERVICE_ID_O = s_q.service_identifier;
   assign MSG_DONE_O = s_q.done;
   assign TOTAL_BYTES_O = s_q.total;
endmodule

/* verif/rrf_link_sva.sv */
`timescale 1ns/1ps
module rrf_link_sva
   import rrf_pkg::*;
(
   input wire logic MCLK_I,
   input wire logic RST_I,
   input wire logic valid,
   input wire logic ready,
   input wire logic [7:0] data,
   input wire logic sof,
   input wire logic eof
);
   logic acc;
   logic [15:0] idx;
   logic [15:0] idx_q;
   logic [7:0] seq_q;
   logic [7:0] cur_q;
   logic [7:0] cnt_q;
   logic [7:0] sid_q;
   logic [31:0] crc_q;
   logic [31:0] crc_nx;

   function automatic logic [31:0] crc_f(input logic [31:0] c0, input logic [7:0] b);
      logic [31:0] c;
      c = c0 ^ {24'h000000, b};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ 32'hedb88320) : (c >> 1);
      end
      return c;
   endfunction

   assign acc = valid && ready;
   assign idx = sof ? 16'h0000 : idx_q;
   assign crc_nx = crc_f(sof ? 32'hffffffff : crc_q, data);

   // Tracks position in the frame and the fields of the first fragment.
   always_ff @(posedge MCLK_I)
   begin
      if (RST_I)
      begin
         idx_q <= 16'h0000;
         seq_q <= 8'h01;
         cur_q <= 8'h00;
         cnt_q <= 8'h00;
         sid_q <= 8'h00;
         crc_q <= 32'hffffffff;
      end
      else if (acc)
      begin
         idx_q <= idx + 16'h0001;
         crc_q <= crc_nx;
         if (idx == 16'h0004)
            cur_q <= data;
         if (idx == 16'h0003 && seq_q == 8'h01)
            cnt_q <= data;
         if (idx == 16'h0001 && seq_q == 8'h01)
            sid_q <= data;
         if (eof)
            seq_q <= (cur_q == cnt_q) ? 8'h01 : cur_q + 8'h01;
      end
   end

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (RST_I);

   beat_hold_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(sof)
      && $stable(eof)) else $error("beat changed while stalled");
   msg_type_a: assert property (acc && sof |-> data == RRF_TYPE_MULTI)
      else $error("wrong message type");
   seq_order_a: assert property (acc && idx == 16'h0004 |-> data == seq_q)
      else $error("fragment sequence out of order");
   seq_range_a: assert property (acc && idx == 16'h0004 |-> data != 8'h00 && data <= cnt_q)
      else $error("sequence outside count");
   count_same_a: assert property (acc && idx == 16'h0003 && seq_q != 8'h01 |-> data == cnt_q)
      else $error("fragment count changed");
   sid_keep_a: assert property (acc && idx == 16'h0001 && seq_q != 8'h01 |-> data == sid_q)
      else $error("identifier changed");
   frame_crc_a: assert property (acc && eof |-> crc_nx == 32'hdebb20e3)
      else $error("frame check value wrong");
   frame_len_a: assert property (acc && eof |-> idx >= RRF_HDR_BYTES + 16'h0003
      && idx <= RRF_MAX_PAYLOAD + 16'h0003)
      else $error("frame length out of range");
   frame_mark_a: assert property (acc |=> !valid || sof == $past(eof))
      else $error("start marker misplaced");

   cover property (acc && idx == 16'h0004 && data == 8'h02);
   cover property (valid && !ready);
   cover property (acc && eof && cur_q == cnt_q);
endmodule

/* verif/test_registration_request_framer.sv */
`timescale 1ns/1ps
module test_registration_request_framer;
   import rrf_pkg::*;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] service_identifier = 16'h0000;
   logic cfg = 1'b0;
   logic tv = 1'b0;
   logic [7:0] tdata = 8'h00;
   logic tfirst = 1'b0;
   logic tlast = 1'b0;
   rrf_group_t tgrp = RRF_GRP_NONE;
   logic tself = 1'b0;
   logic [15:0] tlen = 16'h0000;
   logic gdone = 1'b0;
   logic stall = 1'b0;
   logic tready, busy, done, err, fok, fbad, mdone;
   logic [7:0] fcnt, rcnt, rseq;
   logic [15:0] rsid, rtot;
   bit stall_en = 1'b0;
   int fail_count = 0;
   int tests_run = 0;
   int ok_n = 0;
   int mdone_n = 0;
   int fs;
   logic [10:0] exp_q[$];
   logic [7:0] kq[$];
   int fend[$];

   rrf_link_if link_if ();
   rrf_modem_framer rrf_modem_framer_i (.MCLK_I(mclk), .RST_I(rst), .SERVICE_ID_I(service_identifier),
      .CFG_DONE_I(cfg), .TLV_VALID_I(tv), .TLV_READY_O(tready), .TLV_DATA_I(tdata),
      .TLV_FIRST_I(tfirst), .TLV_LAST_I(tlast), .TLV_GROUP_I(tgrp), .TLV_SELF_I(tself),
      .TLV_LEN_I(tlen), .GEN_DONE_I(gdone), .BUSY_O(busy), .DONE_O(done), .ERROR_O(err),
      .FRAG_COUNT_O(fcnt), .link(link_if));
   rrf_headend_rx rrf_headend_rx_i (.MCLK_I(mclk), .RST_I(rst), .STALL_I(stall),
      .FRAG_OK_O(fok), .FRAG_BAD_O(fbad), .SEQ_O(rseq), .COUNT_O(rcnt), .SERVICE_ID_O(rsid),
      .MSG_DONE_O(mdone), .TOTAL_BYTES_O(rtot), .link(link_if));
   rrf_link_sva rrf_link_sva_i (.MCLK_I(mclk), .RST_I(rst), .valid(link_if.valid),
      .ready(link_if.ready), .data(link_if.data), .sof(link_if.sof), .eof(link_if.eof));

   always #4 mclk = ~mclk;

   always @(posedge mclk)
   begin
      #1;
      stall <= stall_en && ($urandom_range(3) == 0);
   end

   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic fail(input string m);
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
   endtask

   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
         fail(m);
   endtask

   task automatic tick(inout int k, input string m);
      @(posedge mclk);
      k++;
      if (k > 30000)
      begin
         fail(m);
         give_verdict();
      end
   endtask

   // Each accepted link beat is matched against the oldest expected beat.
   always @(posedge mclk)
   begin
      logic [10:0] e;
      if (link_if.valid === 1'b1 && link_if.ready === 1'b1)
      begin
         if (exp_q.size() == 0)
            fail("unexpected link beat");
         else
         begin
            e = exp_q.pop_front();
            chk((!e[10] || link_if.data === e[7:0]) && link_if.sof === e[9]
               && link_if.eof === e[8], "link beat mismatch");
         end
      end
      if (fok === 1'b1)
         ok_n++;
      if (mdone === 1'b1)
         mdone_n++;
      if (fbad === 1'b1)
         fail("fragment rejected by receiver");
   end

   function automatic void pe(input logic [7:0] d, input logic s, input logic e, input logic c);
      exp_q.push_back({c, s, e, d});
   endfunction

   task automatic put_byte(input logic [7:0] b, input int i, input int len, input rrf_group_t g,
      input logic s);
      int k;
      tv = 1'b1;
      tdata = b;
      tfirst = (i == 0);
      tlast = (i == len - 1);
      tlen = 16'(len);
      tgrp = g;
      tself = s;
      k = 0;
      tick(k, "tuple byte not taken");
      while (tready !== 1'b1)
         tick(k, "tuple byte not taken");
      #1;
   endtask

   task automatic put_tlv(input logic [7:0] t, input int len, input rrf_group_t g, input logic s);
      logic [7:0] b;
      bit keep;
      keep = s || g != RRF_GRP_NONE;
      if (keep && kq.size() - fs + len > int'(RRF_MAX_PAYLOAD - RRF_HDR_BYTES))
      begin
         fend.push_back(kq.size());
         fs = kq.size();
      end
      for (int i = 0; i < len; i++)
      begin
         b = (i == 0) ? t : 8'($urandom());
         if (keep)
            kq.push_back(b);
         put_byte(b, i, len, g, s);
      end
   endtask

   task automatic send_msg(input int nbig, input int omit, input int msgs);
      int k;
      int s0;
      int nf;
      bit good;
      good = (omit == 0);
      kq.delete();
      fend.delete();
      fs = 0;
      ok_n = 0;
      service_identifier = 16'($urandom());
      cfg = 1'b1;
      @(posedge mclk);
      #1;
      cfg = 1'b0;
      if (omit != 1)
         put_tlv(RRF_TLV_MODEM_CAP, 3, RRF_GRP_NONE, 1'b1);
      if (omit != 2)
         put_tlv(RRF_TLV_VENDOR_ID, 3, RRF_GRP_NONE, 1'b1);
      if (omit != 3)
         put_tlv(RRF_TLV_RX_PROFILE, 3, RRF_GRP_NONE, 1'b1);
      put_tlv(RRF_TLV_MODEM_IP, 6, RRF_GRP_NONE, 1'b1);
      for (int i = 0; i < nbig; i++)
      begin
         put_tlv(8'h40 + 8'(i), 4, RRF_GRP_NONE, 1'b0);
         put_tlv(8'h20 + 8'(i), 200, rrf_group_t'(i % 3 + 1), 1'b0);
      end
      tv = 1'b0;
      chk(busy === 1'b1, "framer not busy while collecting");
      fend.push_back(kq.size());
      nf = fend.size();
      s0 = 0;
      for (int f = 0; f < nf && good; f++)
      begin
         pe(RRF_TYPE_MULTI, 1'b1, 1'b0, 1'b1);
         pe(service_identifier[15:8], 1'b0, 1'b0, 1'b1);
         pe(service_identifier[7:0], 1'b0, 1'b0, 1'b1);
         pe(8'(nf), 1'b0, 1'b0, 1'b1);
         pe(8'(f + 1), 1'b0, 1'b0, 1'b1);
         for (int b = s0; b < fend[f]; b++)
            pe(kq[b], 1'b0, 1'b0, 1'b1);
         for (int b = 0; b < 4; b++)
            pe(8'h00, 1'b0, b == 3, 1'b0);
         s0 = fend[f];
      end
      gdone = 1'b1;
      @(posedge mclk);
      #1;
      gdone = 1'b0;
      k = 0;
      while (done !== 1'b1 && err !== 1'b1)
         tick(k, "message never finished");
      #1;
      if (!good)
      begin
         chk(err === 1'b1, "missing mandatory tuple not refused");
         return;
      end
      chk(err === 1'b0, "good message refused");
      k = 0;
      while (exp_q.size() != 0 || mdone_n != msgs)
         tick(k, "fragments not received");
      #1;
      chk(fcnt === 8'(nf), "framer count wrong");
      chk(rcnt === 8'(nf), "receiver count wrong");
      chk(rsid === service_identifier, "receiver identifier wrong");
      chk(ok_n == nf, "fragments not all accepted");
      chk(rseq === 8'(nf), "receiver last sequence wrong");
      chk(rtot === 16'(kq.size()), "receiver payload total wrong");
      chk(busy === 1'b0, "framer still busy after message");
   endtask

   initial
   begin
      void'($urandom(60));
      repeat (20) @(posedge mclk);
      #1;
      rst = 1'b0;
      tv = 1'b1;
      repeat (8)
      begin
         @(posedge mclk);
         chk(tready === 1'b0, "tuple taken before configuration");
      end
      #1;
      tv = 1'b0;
      $display("Test early tuples done");
      send_msg(3, 0, 1);
      $display("Test single fragment done");
      stall_en = 1'b1;
      send_msg(10, 0, 2);
      stall_en = 1'b0;
      $display("Test two fragments with stalls done");
      for (int m = 1; m <= 3; m++)
         send_msg(1, m, 2);
      $display("Test missing mandatory tuples done");
      send_msg(2, 0, 3);
      $display("Test recovery done");
      give_verdict();
   end
endmodule
